// ===== core/ptick_pkg.sv
// types shared by the tick block
package ptick_pkg;
   typedef enum logic [1:0] {PTICK_SRC_XTAL, PTICK_SRC_RC, PTICK_SRC_SYS} ptick_src_type;
   typedef enum logic [1:0] {PTICK_TB_12, PTICK_TB_13, PTICK_TB_14, PTICK_TB_15} ptick_tb_type;
endpackage : ptick_pkg

// ===== core/ptick_regs.svh
// register offsets, field positions, reset values and timing constants of the tick block
`ifndef PTICK_REGS_SVH
`define PTICK_REGS_SVH
// byte addresses on the register bus
`define PTICK_OFF_TPC 4'h0
`define PTICK_OFF_IRQ 4'h4
`define PTICK_OFF_SYS 4'h8
// tick_period_control fields
`define PTICK_TPC_LVO 5
`define PTICK_TPC_QSC 4
`define PTICK_TPC_LVE 3
`define PTICK_TPC_RESET 8'h07
`define PTICK_TPC_WMASK 8'h1F
// interrupt control register fields
`define PTICK_IRQ_GIE 0
`define PTICK_IRQ_TIE 1
`define PTICK_IRQ_BIE 2
`define PTICK_IRQ_MIE 3
`define PTICK_IRQ_TRF 4
`define PTICK_IRQ_BRF 5
`define PTICK_IRQ_MRF 6
`define PTICK_IRQ_RESET 8'h00
// core sequencer register fields
`define PTICK_SYS_SLP 0
`define PTICK_SYS_STK 1
`define PTICK_SYS_SVC 2
`define PTICK_SYS_RETURN_FROM_INTERRUPT 3
`define PTICK_SYS_RET 4
// vector and divider geometry
`define PTICK_VECTOR 12'h024
`define PTICK_TICK_MIN_EXP 8
`define PTICK_DIV_BITS 16
`define PTICK_SYSDIV 2'h3
// response codes
`define PTICK_RESP_OKAY 2'h0
`define PTICK_RESP_SLVERR 2'h2
`endif

// ===== core/ptick_top.sv
// periodic tick and time-base request flags with multi-function vectoring, AXI4-Lite slave
// Operation
// - tick interrupt needs global, tick and multi0 enables all set
// - tick request flag sets on every tick divider overflow
// - enabled tick overflow with stack not full calls vector 24H
// - servicing clears global enable and multi0 flag, tick flag stays
// - tick period is source divided by 2^8 to 2^15
// - source is crystal, internal RC, or system clock divided by four
// - low-voltage output bit reads 0 normal, 1 low, read-only
// - quick-start bit: 0 enables, 1 disables quick start
// - detector enable bit: 0 off, 1 on
// - register bits 7 and 6 read as zero
// - time-base interrupt needs global, time-base and multi0 enables
// - time-base overflow sets its flag, enabled calls vector 24H
// - time-base service clears global enable and multi0 flag only
// - time-base period fixed by option, 2^12 to 2^15
// - set request flags hold regardless of enables until cleared
// - rising edge of any request flag wakes from sleep or idle
// - interrupt entry pushes only the program counter
// - interrupt return sets global enable, plain return leaves it clear
// - multi0 flag sets when an enabled tick or time-base overflow raises a request
// - multi0 flag clears by hardware when its vector is taken
`timescale 1ns/10ps
`default_nettype none
`include "ptick_regs.svh"
module ptick_top
   import ptick_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // configuration options, slow clock pins and low-voltage input
   input wire ptick_pkg::ptick_src_type srcSelect,
   input wire ptick_pkg::ptick_tb_type timebaseSelect,
   input wire logic crystalSlowOsc,
   input wire logic internalSlowRcOsc,
   input wire logic lowVoltageIn,
   // analogue control outputs
   output logic oscQuickStartCtrl,
   output logic lowVoltageDetectEnable,
   // core sequencer side
   output logic vectorRequest,
   output logic [11:0] vectorAddress,
   output logic pushPc,
   output logic wakeUp,
   // axi4-lite write address
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import ptick_pkg::*;

   // pin synchronisers, three inputs each through three flops
   // the second and third stages feed the edge detectors, the third the low-voltage bit; no logic reads
   // the first stage; costs one extra cycle of latency on every pin
   logic [2:0] syncA;
   logic [2:0] syncB;
   logic [2:0] syncC;
   wire logic [2:0] pinsRaw = {lowVoltageIn, internalSlowRcOsc, crystalSlowOsc};
   always_ff @(posedge mclk)
   begin
      syncA <= pinsRaw;
      syncB <= syncA;
      syncC <= syncB;
   end
   wire logic xtalRise = syncB[0] & ~syncC[0];
   wire logic rcRise = syncB[1] & ~syncC[1];

   // system clock divided by four as a one-cycle enable
   logic [1:0] sysDiv;
   always_ff @(posedge mclk)
   begin
      if (srst)
         sysDiv <= 2'h0;
      else
         sysDiv <= sysDiv + 2'h1;
   end
   // one pulse per slow-clock rising edge or per four system clocks, whichever source the option picks
   logic srcTick;
   always_comb
   begin
      unique case (srcSelect)
         PTICK_SRC_XTAL: srcTick = xtalRise;
         PTICK_SRC_RC: srcTick = rcRise;
         PTICK_SRC_SYS: srcTick = (sysDiv == `PTICK_SYSDIV);
         default: srcTick = 1'b0;
      endcase
   end

   // shared free-running divider; both periods are powers of two of the same count
   logic [`PTICK_DIV_BITS-1:0] divCount;
   logic [`PTICK_DIV_BITS-1:0] prevCount;
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         divCount <= '0;
         prevCount <= '0;
      end
      else if (srcTick)
      begin
         divCount <= divCount + 16'h0001;
         prevCount <= divCount;
      end
   end
   // bit n falling after an increment marks an overflow of a 2^(n+1) divider
   function automatic logic carry_at(input logic [3:0] bitIdx, input logic [15:0] now,
                                     input logic [15:0] was);
      carry_at = was[bitIdx] & ~now[bitIdx];
   endfunction : carry_at
   logic tickStep;
   logic tbStep;
   always_ff @(posedge mclk)
   begin
      if (srst)
         tickStep <= 1'b0;
      else
         tickStep <= srcTick;
   end
   assign tbStep = tickStep;

   // registers
   logic [7:0] tpc;
   logic [6:0] irqCtl;
   wire logic [2:0] tickPeriodSelect = tpc[2:0];
   // code k selects carry out of bit 7+k, period 2^(8+k)
   wire logic [3:0] tickBit = 4'(`PTICK_TICK_MIN_EXP - 1) + {1'b0, tickPeriodSelect};
   wire logic [3:0] tbBit = 4'h3 + {2'h0, timebaseSelect} + 4'h8;
   // option-fixed time base, 2^12..2^15
   wire logic tickOverflow = tickStep & carry_at(tickBit, divCount, prevCount);
   wire logic tbOverflow = tbStep & carry_at(tbBit, divCount, prevCount);

   // address decode shared by both channels
   function automatic logic reg_hit(input logic [3:0] addr);
      reg_hit = (addr == `PTICK_OFF_TPC) | (addr == `PTICK_OFF_IRQ) | (addr == `PTICK_OFF_SYS);
   endfunction : reg_hit

   // bus side
   logic awHeld;
   logic wHeld;
   logic [3:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   wire logic doWrite = awHeld & wHeld & ~s_axi_bvalid;
   wire logic wrTpc = doWrite & (awAddr == `PTICK_OFF_TPC) & wStrb[0];
   wire logic wrIrq = doWrite & (awAddr == `PTICK_OFF_IRQ) & wStrb[0];
   wire logic wrSys = doWrite & (awAddr == `PTICK_OFF_SYS) & wStrb[0];
   wire logic wrHit = reg_hit(awAddr);
   wire logic awTaken = s_axi_awvalid & s_axi_awready;
   wire logic wTaken = s_axi_wvalid & s_axi_wready;
   wire logic arTaken = s_axi_arvalid & s_axi_arready;

   // core sequencer commands written by the bench playing the core
   wire logic stackFull = wrSys & wData[`PTICK_SYS_STK];
   wire logic svcAck = wrSys & wData[`PTICK_SYS_SVC];
   wire logic retiCmd = wrSys & wData[`PTICK_SYS_RETURN_FROM_INTERRUPT];
   wire logic retCmd = wrSys & wData[`PTICK_SYS_RET];
   logic stackFullLvl;
   logic sleeping;

   // flag and enable update
   wire logic gie = irqCtl[`PTICK_IRQ_GIE];
   wire logic mfEnable = irqCtl[`PTICK_IRQ_MIE];
   wire logic tickFlag = irqCtl[`PTICK_IRQ_TRF];
   wire logic tbFlag = irqCtl[`PTICK_IRQ_BRF];
   wire logic mfFlag = irqCtl[`PTICK_IRQ_MRF];
   // multi0 flag follows either source overflowing with its own enable set
   wire logic mfSet = (tickOverflow & irqCtl[`PTICK_IRQ_TIE]) |
                      (tbOverflow & irqCtl[`PTICK_IRQ_BIE]);
   // vector taken only with all enables and room on the stack
   wire logic takeVector = gie & mfEnable & mfFlag & ~stackFullLvl & ~vectorRequest;
   logic [6:0] next_irqCtl;
   always_comb
   begin
      next_irqCtl = irqCtl;
      if (wrIrq)
         next_irqCtl = wData[6:0];
      // entry clears global enable and multi0 flag, source flags untouched
      if (takeVector)
      begin
         next_irqCtl[`PTICK_IRQ_GIE] = 1'b0;
         next_irqCtl[`PTICK_IRQ_MRF] = 1'b0;
      end
      // interrupt return re-arms, plain return keeps it clear
      if (retiCmd)
         next_irqCtl[`PTICK_IRQ_GIE] = 1'b1;
      // sets win over software clears; flags hold whatever the enables do
      if (tickOverflow)
         next_irqCtl[`PTICK_IRQ_TRF] = 1'b1;
      if (tbOverflow)
         next_irqCtl[`PTICK_IRQ_BRF] = 1'b1;
      if (mfSet)
         next_irqCtl[`PTICK_IRQ_MRF] = 1'b1;
   end
   wire logic anyRise = (next_irqCtl[`PTICK_IRQ_TRF] & ~tickFlag) |
                        (next_irqCtl[`PTICK_IRQ_BRF] & ~tbFlag) |
                        (next_irqCtl[`PTICK_IRQ_MRF] & ~mfFlag);

   // writable bits only; bit 5 is the live detector, 7:6 stay zero
   always_ff @(posedge mclk)
   begin
      if (srst)
         tpc <= `PTICK_TPC_RESET;
      else
      begin
         if (wrTpc)
            tpc[4:0] <= wData[4:0] & 5'(`PTICK_TPC_WMASK);
         tpc[`PTICK_TPC_LVO] <= syncC[2];
      end
   end
   // interrupt control register
   always_ff @(posedge mclk)
   begin
      if (srst)
         irqCtl <= 7'(`PTICK_IRQ_RESET);
      else
         irqCtl <= next_irqCtl;
   end
   // core stand-in levels; wake on any flag rising while asleep or idle
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         stackFullLvl <= 1'b0;
         sleeping <= 1'b0;
      end
      else if (wrSys)
      begin
         stackFullLvl <= stackFull;
         sleeping <= wData[`PTICK_SYS_SLP];
      end
      else if (anyRise)
         sleeping <= 1'b0;
   end
   // single-cycle wake pulse toward the core
   always_ff @(posedge mclk)
   begin
      if (srst)
         wakeUp <= 1'b0;
      else
         wakeUp <= sleeping & anyRise;
   end
   // request held until the core acknowledges or issues a plain return; only the pc is pushed
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         vectorRequest <= 1'b0;
         pushPc <= 1'b0;
      end
      else
      begin
         if (takeVector)
            vectorRequest <= 1'b1;
         else if (svcAck | retCmd)
            vectorRequest <= 1'b0;
         pushPc <= takeVector;
      end
   end
   // vector address latched at entry
   always_ff @(posedge mclk)
   begin
      if (srst)
         vectorAddress <= 12'h000;
      else if (takeVector)
         vectorAddress <= `PTICK_VECTOR;
   end
   // quick start active low, detector enable active high
   assign oscQuickStartCtrl = tpc[`PTICK_TPC_QSC];
   assign lowVoltageDetectEnable = tpc[`PTICK_TPC_LVE];

   // write channel: address and data in either order, response after both
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 4'h0;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
      end
      else
      begin
         if (awTaken)
         begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (wTaken)
         begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite)
         begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
         end
      end
   end
   // response stands until the master takes it
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PTICK_RESP_OKAY;
      end
      else if (doWrite)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrHit ? `PTICK_RESP_OKAY : `PTICK_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         s_axi_awready <= ~awHeld & ~awTaken & ~s_axi_bvalid;
         s_axi_wready <= ~wHeld & ~wTaken & ~s_axi_bvalid;
      end
   end

   // read channel, one cycle after the address is taken
   wire logic rdHit = reg_hit(s_axi_araddr);
   wire logic [31:0] sysView = {27'h0, 3'h0, stackFullLvl, sleeping};
   wire logic [31:0] rdMux = (s_axi_araddr == `PTICK_OFF_TPC) ? {24'h0, 2'h0, tpc[5:0]} :
                             (s_axi_araddr == `PTICK_OFF_IRQ) ? {25'h0, irqCtl} :
                             (s_axi_araddr == `PTICK_OFF_SYS) ? sysView : 32'h0000_0000;
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `PTICK_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= ~s_axi_rvalid & ~arTaken;
         if (arTaken)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdHit ? `PTICK_RESP_OKAY : `PTICK_RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule : ptick_top
`default_nettype wire

// ===== testbench/periodic_tick_interrupts_test.sv
// self-checking bench for the tick block
`timescale 1ns/10ps
`default_nettype none
`include "ptick_regs.svh"
module periodic_tick_interrupts_test;
   import ptick_pkg::*;
   logic mclk = 1'b0, srst = 1'b1, lowVoltageIn = 1'b0, crystalSlowOsc, internalSlowRcOsc;
   ptick_src_type srcSelect = PTICK_SRC_SYS;
   ptick_tb_type timebaseSelect = PTICK_TB_12;
   logic oscQuickStartCtrl, lowVoltageDetectEnable, vectorRequest, pushPc, wakeUp;
   logic [11:0] vectorAddress;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0;
   logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   int fails = 0, checks_done = 0;
   always #5 mclk = ~mclk;
   ptick_slow_osc osc (.crystalSlowOsc, .internalSlowRcOsc);
   ptick_top dut (.mclk, .srst, .srcSelect, .timebaseSelect, .crystalSlowOsc, .internalSlowRcOsc,
      .lowVoltageIn, .oscQuickStartCtrl, .lowVoltageDetectEnable, .vectorRequest, .vectorAddress,
      .pushPc, .wakeUp, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task near(input int n, input int e);
      chk(32'(n >= e - 2 && n <= e + 2), 32'h1);
   endtask : near
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask : wr
   task rdreg(input logic [3:0] a);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rdreg
   task rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      rdreg(a);
      chk(rd & {24'hFFFFFF, m}, {24'h000000, e});
   endtask : rchk
   // first vector only aligns the divider phase, the second gives the period
   task measure(input logic [7:0] irq, output int n);
      time t0;
      wr(`PTICK_OFF_IRQ, irq);
      wr(`PTICK_OFF_SYS, 8'h04);
      while (vectorRequest !== 1'b1) @(posedge mclk);
      t0 = $time;
      wr(`PTICK_OFF_SYS, 8'h04);
      wr(`PTICK_OFF_IRQ, irq);
      while (vectorRequest !== 1'b1) @(posedge mclk);
      n = int'(($time - t0) / 10);
   endtask : measure
   task t_regs;
      rchk(`PTICK_OFF_TPC, 8'hFF, 8'h07);
      rchk(`PTICK_OFF_IRQ, 8'hFF, 8'h00);
      wr(`PTICK_OFF_TPC, 8'hFF);
      chk({30'h0, oscQuickStartCtrl, lowVoltageDetectEnable}, 32'h3);
      rchk(`PTICK_OFF_TPC, 8'hFF, 8'h1F);
      lowVoltageIn <= 1'b1;
      repeat (4) @(posedge mclk);
      wr(`PTICK_OFF_TPC, 8'h00);
      chk({30'h0, oscQuickStartCtrl, lowVoltageDetectEnable}, 32'h0);
      rchk(`PTICK_OFF_TPC, 8'hFF, 8'h20);
      lowVoltageIn <= 1'b0;
      rdreg(4'hC);
      chk(32'(rr), 32'(`PTICK_RESP_SLVERR));
   endtask : t_regs
   task t_tick;
      int n;
      for (int i = 0; i < 3; i++)
      begin
         srcSelect <= (i == 0) ? PTICK_SRC_SYS : (i == 1) ? PTICK_SRC_XTAL : PTICK_SRC_RC;
         measure(8'h0B, n);
         near(n, (i == 2) ? 2048 : 1024);
      end
      chk(32'(vectorAddress), 32'h24);
      rchk(`PTICK_OFF_IRQ, 8'hFF, 8'h1A);
      srcSelect <= PTICK_SRC_SYS;
      wr(`PTICK_OFF_TPC, 8'h01);
      measure(8'h0B, n);
      near(n, 2048);
   endtask : t_tick
   task t_gate;
      wr(`PTICK_OFF_SYS, 8'h04);
      wr(`PTICK_OFF_IRQ, 8'h09);
      repeat (2100) @(posedge mclk);
      chk(32'(vectorRequest), 32'h0);
      rchk(`PTICK_OFF_IRQ, 8'hFF, 8'h19);
      wr(`PTICK_OFF_SYS, 8'h06);
      wr(`PTICK_OFF_IRQ, 8'h0B);
      repeat (2100) @(posedge mclk);
      chk(32'(vectorRequest), 32'h0);
      rchk(`PTICK_OFF_IRQ, 8'hDF, 8'h5B);
   endtask : t_gate
   task t_base;
      int n;
      wr(`PTICK_OFF_TPC, 8'h07);
      measure(8'h0D, n);
      near(n, 16384);
      chk(32'(vectorAddress), 32'h24);
      rchk(`PTICK_OFF_IRQ, 8'hEF, 8'h2C);
   endtask : t_base
   task t_ret;
      wr(`PTICK_OFF_IRQ, 8'h00);
      wr(`PTICK_OFF_SYS, 8'h08);
      rchk(`PTICK_OFF_IRQ, 8'h01, 8'h01);
      wr(`PTICK_OFF_IRQ, 8'h00);
      wr(`PTICK_OFF_SYS, 8'h10);
      rchk(`PTICK_OFF_IRQ, 8'h01, 8'h00);
   endtask : t_ret
   // sleep first: a flag cleared afterwards must rise again to wake
   task t_wake;
      int n;
      wr(`PTICK_OFF_TPC, 8'h00);
      wr(`PTICK_OFF_SYS, 8'h01);
      wr(`PTICK_OFF_IRQ, 8'h00);
      for (n = 0; n < 1200 && wakeUp !== 1'b1; n++) @(posedge mclk);
      chk(32'(n < 1200), 32'h1);
   endtask : t_wake
   task results;
      if (fails == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results
   initial
   begin
      repeat (12) @(posedge mclk);
      srst <= 1'b0;
      t_regs();
      t_tick();
      t_gate();
      t_base();
      t_ret();
      t_wake();
      results();
   end
   initial
   begin
      #900000;
      fails++;
      results();
   end
endmodule : periodic_tick_interrupts_test
`default_nettype wire

// ===== testbench/ptick_checker.sv
// concurrent checks on the tick block ports
`timescale 1ns/10ps
`default_nettype none
`include "ptick_regs.svh"
module ptick_checker (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // core side
   input wire logic oscQuickStartCtrl,
   input wire logic lowVoltageDetectEnable,
   input wire logic vectorRequest,
   input wire logic [11:0] vectorAddress,
   input wire logic pushPc,
   input wire logic wakeUp,
   // bus side
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [3:0] rdAddr;
   // address of the read in flight, to judge its data
   always_ff @(posedge mclk)
   begin
      if (srst)
         rdAddr <= 4'h0;
      else if (s_axi_arvalid && s_axi_arready)
         rdAddr <= s_axi_araddr;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   property p_vec_addr;
      $rose(vectorRequest) |-> vectorAddress == `PTICK_VECTOR;
   endproperty
   a_vec_addr: assert property (p_vec_addr) else $error("bad vector address");
   property p_push_rise;
      $rose(vectorRequest) |-> pushPc;
   endproperty
   a_push_rise: assert property (p_push_rise) else $error("no push on entry");
   property p_push_only;
      pushPc |-> vectorRequest ##1 !pushPc;
   endproperty
   a_push_only: assert property (p_push_only) else $error("stray push");
   property p_wake;
      wakeUp |=> !wakeUp;
   endproperty
   a_wake: assert property (p_wake) else $error("wake not a pulse");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   property p_upper;
      s_axi_rvalid && rdAddr == 4'h0 |-> s_axi_rdata[31:6] == 26'h0;
   endproperty
   a_upper: assert property (p_upper) else $error("upper bits not zero");
   property p_unmapped;
      s_axi_rvalid && rdAddr == 4'hC |-> s_axi_rresp == `PTICK_RESP_SLVERR && s_axi_rdata == 0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
   property p_ctrl;
      $changed(oscQuickStartCtrl) || $changed(lowVoltageDetectEnable) |-> $rose(s_axi_bvalid);
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control moved alone");
   c_vec: cover property ($rose(vectorRequest));
   c_wake: cover property (wakeUp);
   c_err: cover property (s_axi_rvalid && s_axi_rresp == `PTICK_RESP_SLVERR);
endmodule : ptick_checker
bind ptick_top ptick_checker chk (.mclk, .srst, .oscQuickStartCtrl, .lowVoltageDetectEnable,
   .vectorRequest, .vectorAddress, .pushPc, .wakeUp, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready);
`default_nettype wire

// ===== testbench/ptick_slow_osc.sv
// free-running slow oscillator pins that feed the tick source
`timescale 1ns/10ps
`default_nettype none
module ptick_slow_osc (
   // slow clock pins
   output logic crystalSlowOsc,
   output logic internalSlowRcOsc
);
   // far faster than real parts so the run stays short
   initial
   begin
      crystalSlowOsc = 1'b0;
      #3;
      forever #20 crystalSlowOsc = ~crystalSlowOsc;
   end
   initial
   begin
      internalSlowRcOsc = 1'b0;
      #7;
      forever #40 internalSlowRcOsc = ~internalSlowRcOsc;
   end
endmodule : ptick_slow_osc
`default_nettype wire
